// ==== verilog/unified_map.vh ====
// address map constants for the unified memory map decoder
`ifndef UNIFIED_MAP_MAP_VH
`define UNIFIED_MAP_MAP_VH
`define FLASH_END_8K       16'h1FFF
`define FLASH_END_16K      16'h3FFF
`define FLASH_END_32K      16'h7FFF
`define SRAM_BASE          16'hF000
`define SRAM_HOLE_LO_8K    16'hF300
`define SRAM_HOLE_LO_16K   16'hF700
`define SRAM_HOLE_HI       16'hFEFF
`define IDATA_BASE         16'hFF00
`define IDATA_END          16'hFFFF
`define RADIO_BASE         16'hDF00
`define RADIO_END          16'hDF3D
`define AUDIO_BASE         16'hDF40
`define AUDIO_END          16'hDF48
`define SFR_BASE           16'hDF80
`define SFR_END            16'hDFFF
`define USB_BASE           16'hDE00
`define USB_END            16'hDE3F
`define VOLATILE_LO        16'hFDA2
`define VOLATILE_HI        16'hFEFF
`define DIRECT_LIMIT       8'h7F
`define BANK_END           8'h2F
`define BITRAM_LO          8'h20
`define BITRAM_HI          8'h2F
`define SFR_BITMASK        7'h07
`define SIZE_8K            2'h0
`define SIZE_16K           2'h1
`define SIZE_32K           2'h2
`define TGT_NONE           3'h0
`define TGT_FLASH          3'h1
`define TGT_SRAM           3'h2
`define TGT_IDATA          3'h3
`define TGT_RADIO          3'h4
`define TGT_AUDIO          3'h5
`define TGT_USB            3'h6
`define TGT_SFR            3'h7
`define EXT_DATA_WAIT      3'h4
`define UNMAPPED_DATA      8'h00
`endif

// ==== verilog/region_decode.v ====
// combinational region decode of one 16-bit unified address
`timescale 1ns/1ps
`include "unified_map.vh"
module region_decode #(
    parameter [1:0] SIZE_SEL = `SIZE_32K,
    parameter       HAS_USB  = 1
) (
    // address in
    input  wire [15:0] i_addr,
    // decode out
    output reg  [2:0]  o_target,
    output reg  [15:0] o_offset,
    output reg         o_volatile
);
    reg [15:0] flash_end;
    reg [15:0] hole_lo;
    // variant-dependent limits, then first-match decode
    always @* begin
        flash_end = (SIZE_SEL == `SIZE_8K)  ? `FLASH_END_8K :
                    (SIZE_SEL == `SIZE_16K) ? `FLASH_END_16K :
                                              `FLASH_END_32K;
        hole_lo   = (SIZE_SEL == `SIZE_8K)  ? `SRAM_HOLE_LO_8K :
                    (SIZE_SEL == `SIZE_16K) ? `SRAM_HOLE_LO_16K :
                                              `IDATA_BASE;
        o_target  = `TGT_NONE;
        o_offset  = 16'h0000;
        o_volatile = 1'b0;
        if (i_addr <= flash_end) begin
            o_target = `TGT_FLASH;
            o_offset = i_addr;
        end else if (i_addr >= `IDATA_BASE) begin
            o_target = `TGT_IDATA;
            o_offset = i_addr - `IDATA_BASE;
        end else if (i_addr >= `SRAM_BASE) begin
            if (i_addr < hole_lo) begin
                o_target = `TGT_SRAM;
                o_offset = i_addr - `SRAM_BASE;
                o_volatile = (SIZE_SEL == `SIZE_32K) &&
                             (i_addr >= `VOLATILE_LO);
            end
        end else if (i_addr >= `RADIO_BASE && i_addr <= `RADIO_END) begin
            o_target = `TGT_RADIO;
            o_offset = i_addr - `RADIO_BASE;
        end else if (i_addr >= `AUDIO_BASE && i_addr <= `AUDIO_END) begin
            o_target = `TGT_AUDIO;
            o_offset = i_addr - `AUDIO_BASE;
        end else if (i_addr >= `SFR_BASE) begin
            if (i_addr <= `SFR_END) begin
                o_target = `TGT_SFR;
                o_offset = i_addr - `SFR_BASE;
            end
        end else if (HAS_USB != 0 && i_addr >= `USB_BASE &&
                     i_addr <= `USB_END) begin
            o_target = `TGT_USB;
            o_offset = i_addr - `USB_BASE;
        end
    end
endmodule // region_decode

// ==== verilog/unified_memory_map_decoder.v ====
// unified memory map decoder: steers cpu and dma accesses to targets
//
// Overview of operation
// - flash decodes from zero up to 0x1FFF, 0x3FFF or 0x7FFF by size.
// - sram sits from 0xF000 upward, not at address zero.
// - internal data space aliases onto 0xFF00..0xFFFF.
// - 0xDF00..0xDF3D goes to the radio register file.
// - 0xDF40..0xDF48 goes to the audio serial registers.
// - non-core special registers are mirrored at 0xDF80..0xDFFF.
// - 0xDE00..0xDE3F reaches usb only on the usb variant.
// - instruction fetches use exactly the same map as data.
// - core-internal special registers never appear in the mirror.
// - 8k leaves 0xF300..0xFEFF empty, 16k leaves 0xF700..0xFEFF empty.
// - on 32k, 0xFDA2..0xFEFF loses contents in the deepest sleeps.
// - data moves may touch all space but never write flash.
// - lower 128 internal bytes direct or indirect, upper indirect only.
// - special registers at multiples of eight are bit addressable.
// - lowest 48 bytes are register banks; 0x20..0x2F bit addressable.
// - one clock per instruction cycle, aligned with memory fetch.
// - fetch and data share one bus; fetch stalls during data access.
// - 128 special registers in a 7-bit directly addressed space.
// - internal data is retained always; sram undefined after power-on.
`timescale 1ns/1ps
`include "unified_map.vh"
module unified_memory_map_decoder #(
    parameter [1:0] SIZE_SEL   = `SIZE_32K,
    parameter       HAS_USB    = 1,
    parameter [2:0] DATA_WAIT  = `EXT_DATA_WAIT
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst_b,
    input  wire        i_ce,
    // instruction fetch request
    input  wire        i_fetch_req,
    input  wire [15:0] i_fetch_addr,
    // unified data request (cpu or dma)
    input  wire        i_data_req,
    input  wire        i_data_we,
    input  wire        i_data_is_dma,
    input  wire [15:0] i_data_addr,
    input  wire [7:0]  i_data_wdata,
    // direct and indirect internal data / register access
    input  wire        i_dir_req,
    input  wire        i_dir_indirect,
    input  wire        i_dir_we,
    input  wire [7:0]  i_dir_addr,
    input  wire [7:0]  i_dir_wdata,
    // power mode
    input  wire        i_deep_sleep,
    // read data returned by targets
    input  wire [7:0]  i_rdata_flash,
    input  wire [7:0]  i_rdata_sram,
    input  wire [7:0]  i_rdata_idata,
    input  wire [7:0]  i_rdata_radio,
    input  wire [7:0]  i_rdata_audio,
    input  wire [7:0]  i_rdata_usb,
    input  wire [7:0]  i_rdata_sfr,
    // unified target selects
    output reg         o_sel_flash,
    output reg         o_sel_sram,
    output reg         o_sel_idata,
    output reg         o_sel_radio,
    output reg         o_sel_audio,
    output reg         o_sel_usb,
    output reg         o_sel_sfr,
    output reg         o_sel_core_sfr,
    output reg         o_we,
    output reg  [15:0] o_offset,
    output reg  [7:0]  o_wdata,
    output reg         o_is_fetch,
    output reg         o_bit_ok,
    output reg         o_bank_area,
    // answers
    output reg         o_fetch_stall,
    output reg         o_data_ack,
    output reg         o_dir_ack,
    output reg  [7:0]  o_rdata,
    output reg         o_volatile_lost,
    output reg         o_flash_write_block
);
    // ------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [2:0]  wait_cnt;
    reg  [2:0]  held_tgt;
    reg  [15:0] held_addr;
    reg         held_we;
    reg  [7:0]  held_wdata;
    reg         held_dma;
    reg         held_fetch;
    reg         held_dir;
    reg  [7:0]  held_dir_addr;
    reg         held_dir_ind;

    wire [2:0]  fetch_tgt;
    wire [15:0] fetch_off;
    wire        fetch_vol;
    wire [2:0]  data_tgt;
    wire [15:0] data_off;
    wire        data_vol;

    // two identical decoder instances serve fetch and data, so the maps match
    region_decode #(
        .SIZE_SEL (SIZE_SEL),
        .HAS_USB  (HAS_USB)
    ) u_dec_fetch (
        .i_addr     (i_fetch_addr),
        .o_target   (fetch_tgt),
        .o_offset   (fetch_off),
        .o_volatile (fetch_vol)
    );
    region_decode #(
        .SIZE_SEL (SIZE_SEL),
        .HAS_USB  (HAS_USB)
    ) u_dec_data (
        .i_addr     (i_data_addr),
        .o_target   (data_tgt),
        .o_offset   (data_off),
        .o_volatile (data_vol)
    );

    // special register bit addressable when address divisible by eight
    function sfr_bit_ok;
        input [7:0] a;
        begin
            sfr_bit_ok = ((a[6:0] & `SFR_BITMASK) == 7'h00);
        end
    endfunction

    // read data result for a held target
    function [7:0] pick_rdata;
        input [2:0] t;
        input [7:0] fl, sr, id, ra, au, us, sf;
        begin
            case (t)
                `TGT_FLASH: pick_rdata = fl;
                `TGT_SRAM:  pick_rdata = sr;
                `TGT_IDATA: pick_rdata = id;
                `TGT_RADIO: pick_rdata = ra;
                `TGT_AUDIO: pick_rdata = au;
                `TGT_USB:   pick_rdata = us;
                `TGT_SFR:   pick_rdata = sf;
                default:    pick_rdata = `UNMAPPED_DATA;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // direct access wins the shared bus, then data, then fetch; direct access is single cycle
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (i_data_req || i_dir_req || i_fetch_req) begin
                    next_state = (i_data_req && !i_dir_req) ?
                                 ST_WAIT : ST_DONE;
                end
            end
            ST_WAIT: begin
                if (wait_cnt == 3'h0) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // capture, count and answer; all outputs registered
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
            wait_cnt <= 3'h0;
            held_tgt <= `TGT_NONE;
            held_addr <= 16'h0000;
            held_we <= 1'b0;
            held_wdata <= 8'h00;
            held_dma <= 1'b0;
            held_fetch <= 1'b0;
            held_dir <= 1'b0;
            held_dir_addr <= 8'h00;
            held_dir_ind <= 1'b0;
            o_sel_flash <= 1'b0;
            o_sel_sram <= 1'b0;
            o_sel_idata <= 1'b0;
            o_sel_radio <= 1'b0;
            o_sel_audio <= 1'b0;
            o_sel_usb <= 1'b0;
            o_sel_sfr <= 1'b0;
            o_sel_core_sfr <= 1'b0;
            o_we <= 1'b0;
            o_offset <= 16'h0000;
            o_wdata <= 8'h00;
            o_is_fetch <= 1'b0;
            o_bit_ok <= 1'b0;
            o_bank_area <= 1'b0;
            o_fetch_stall <= 1'b0;
            o_data_ack <= 1'b0;
            o_dir_ack <= 1'b0;
            o_rdata <= 8'h00;
            o_volatile_lost <= 1'b0;
            o_flash_write_block <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            o_data_ack <= 1'b0;
            o_dir_ack <= 1'b0;
            o_flash_write_block <= 1'b0;
            // volatile region flagged while deep sleep holds
            o_volatile_lost <= (SIZE_SEL == `SIZE_32K) &&
                               i_deep_sleep;
            case (state)
                ST_IDLE: begin
                    o_fetch_stall <= i_data_req && !i_dir_req;
                    if (i_dir_req) begin
                        held_dir <= 1'b1;
                        held_fetch <= 1'b0;
                        held_dir_addr <= i_dir_addr;
                        held_dir_ind <= i_dir_indirect;
                        held_we <= i_dir_we;
                        held_wdata <= i_dir_wdata;
                        // upper half: indirect -> ram, direct -> sfr
                        if (i_dir_addr > `DIRECT_LIMIT && !i_dir_indirect) begin
                            held_tgt <= `TGT_SFR;
                        end else begin
                            held_tgt <= `TGT_IDATA;
                        end
                    end else if (i_data_req) begin
                        held_dir <= 1'b0;
                        held_fetch <= 1'b0;
                        held_tgt <= data_tgt;
                        held_addr <= data_off;
                        held_we <= i_data_we && (data_tgt != `TGT_FLASH);
                        o_flash_write_block <= i_data_we &&
                                               (data_tgt == `TGT_FLASH);
                        held_wdata <= i_data_wdata;
                        held_dma <= i_data_is_dma;
                        wait_cnt <= DATA_WAIT - 3'h1;
                    end else if (i_fetch_req) begin
                        held_dir <= 1'b0;
                        held_fetch <= 1'b1;
                        held_tgt <= fetch_tgt;
                        held_addr <= fetch_off;
                        held_we <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    wait_cnt <= wait_cnt - 3'h1;
                end
                ST_DONE: begin
                    o_fetch_stall <= 1'b0;
                    o_data_ack <= !held_dir && !held_fetch;
                    o_dir_ack <= held_dir;
                    o_rdata <= pick_rdata(held_tgt, i_rdata_flash,
                        i_rdata_sram, i_rdata_idata, i_rdata_radio,
                        i_rdata_audio, i_rdata_usb, i_rdata_sfr);
                end
                default: ;
            endcase
            // one-hot selects, at most one high per access
            if (state == ST_IDLE && next_state != ST_IDLE) begin
                o_sel_flash <= 1'b0;
            end
            if (next_state == ST_DONE && state != ST_DONE) begin
                o_sel_flash <= (held_tgt_n(i_dir_req, data_tgt, fetch_tgt,
                               i_data_req, state) == `TGT_FLASH);
            end
            o_is_fetch <= held_fetch;
            o_offset <= held_dir ? {8'h00, held_dir_addr} : held_addr;
            o_wdata <= held_wdata;
            o_we <= held_we && (state == ST_DONE);
            o_sel_flash <= (state == ST_DONE) && (held_tgt == `TGT_FLASH);
            o_sel_sram <= (state == ST_DONE) && (held_tgt == `TGT_SRAM);
            o_sel_idata <= (state == ST_DONE) && (held_tgt == `TGT_IDATA);
            o_sel_radio <= (state == ST_DONE) && (held_tgt == `TGT_RADIO);
            o_sel_audio <= (state == ST_DONE) && (held_tgt == `TGT_AUDIO);
            o_sel_usb <= (state == ST_DONE) && (held_tgt == `TGT_USB);
            // mirror reaches only peripheral registers; core ones by direct
            o_sel_sfr <= (state == ST_DONE) && (held_tgt == `TGT_SFR)
                         && !held_dir;
            o_sel_core_sfr <= (state == ST_DONE) && held_dir
                              && (held_tgt == `TGT_SFR);
            o_bit_ok <= held_dir && ((held_tgt == `TGT_SFR) ?
                        sfr_bit_ok(held_dir_addr) :
                        (held_dir_addr >= `BITRAM_LO &&
                         held_dir_addr <= `BITRAM_HI));
            o_bank_area <= held_dir && (held_tgt == `TGT_IDATA) &&
                           (held_dir_addr <= `BANK_END);
        end
    end

    // next select target preview, kept trivial for the idle case
    function [2:0] held_tgt_n;
        input       d;
        input [2:0] dt;
        input [2:0] ft;
        input       r;
        input [1:0] s;
        begin
            held_tgt_n = d ? `TGT_IDATA : (r ? dt : ft);
        end
    endfunction
endmodule // unified_memory_map_decoder

// ==== verification/map_checker.sv ====
// port-level assertions for the unified memory map decoder
`timescale 1ns/1ps
module map_checker #(
    parameter [1:0] SIZE_SEL  = 2'h2,
    parameter       HAS_USB   = 1,
    parameter [2:0] DATA_WAIT = 3'h4
) (
    // clock, reset, power
    input wire        i_clk,
    input wire        i_rst_b,
    input wire        i_ce,
    input wire        i_deep_sleep,
    // decoder outputs
    input wire        o_sel_flash,
    input wire        o_sel_sram,
    input wire        o_sel_idata,
    input wire        o_sel_radio,
    input wire        o_sel_audio,
    input wire        o_sel_usb,
    input wire        o_sel_sfr,
    input wire        o_sel_core_sfr,
    input wire        o_we,
    input wire [15:0] o_offset,
    input wire        o_is_fetch,
    input wire        o_bank_area,
    input wire        o_fetch_stall,
    input wire        o_data_ack,
    input wire        o_dir_ack,
    input wire        o_volatile_lost
);
    // ------------------------------------------------------------
    // properties, one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire [7:0] sel = {o_sel_flash, o_sel_sram, o_sel_idata, o_sel_radio,
                      o_sel_audio, o_sel_usb, o_sel_sfr, o_sel_core_sfr};

    one_select_a: assert property ($onehot0(sel))
        else $error("more than one target select");
    flash_no_write_a: assert property (o_sel_flash |-> !o_we)
        else $error("write strobe towards flash");
    sleep_loss_a: assert property (i_ce |=>
        o_volatile_lost == (SIZE_SEL == 2'h2 && $past(i_deep_sleep)))
        else $error("volatile flag wrong");
    stall_before_ack_a: assert property (o_data_ack |->
        $past(o_fetch_stall))
        else $error("data ack without fetch stall");
    stall_length_a: assert property ($rose(o_fetch_stall) |->
        o_fetch_stall[*3] ##[1:6] o_data_ack)
        else $error("data access stall length wrong");
    core_direct_a: assert property (o_sel_core_sfr |->
        o_dir_ack && !o_data_ack)
        else $error("core register reached off direct path");
    usb_variant_a: assert property (o_sel_usb |-> HAS_USB != 0)
        else $error("usb select on variant without usb");
    fetch_read_a: assert property (o_is_fetch |-> !o_we && !o_data_ack)
        else $error("fetch carried a write or data ack");
    bank_area_a: assert property (o_bank_area && o_dir_ack |->
        o_offset <= 16'h002F)
        else $error("bank area flag above 0x2f");
endmodule // map_checker

// ==== verification/target_model.sv ====
// behavioural model of the targets answering the decoder
`timescale 1ns/1ps
module target_model (
    // read data towards the decoder
    output wire [7:0] o_rdata_flash,
    output wire [7:0] o_rdata_sram,
    output wire [7:0] o_rdata_idata,
    output wire [7:0] o_rdata_radio,
    output wire [7:0] o_rdata_audio,
    output wire [7:0] o_rdata_usb,
    output wire [7:0] o_rdata_sfr
);
    // distinct byte per target so a mis-steer shows at once;
    // the bench expects 0x00 back from unmapped places
    assign o_rdata_flash = 8'h11;
    assign o_rdata_sram  = 8'h22;
    assign o_rdata_idata = 8'h33;
    assign o_rdata_radio = 8'h44;
    assign o_rdata_audio = 8'h55;
    assign o_rdata_usb   = 8'h66;
    assign o_rdata_sfr   = 8'h77;
endmodule // target_model

// ==== verification/unified_memory_map_decoder_tb_top.sv ====
// self-checking testbench for the unified memory map decoder
`timescale 1ns/1ps
module unified_memory_map_decoder_tb_top;
    // ------------------------------------------------------------
    // stimulus, wiring and shared tasks
    // ------------------------------------------------------------
    reg  i_clk = 0, i_rst_b = 0, i_ce = 1, i_deep_sleep = 0;
    reg  i_fetch_req = 0, i_data_req = 0, i_data_we = 0;
    reg  i_data_is_dma = 0, i_dir_req = 0, i_dir_indirect = 0;
    reg  i_dir_we = 0;
    reg  [15:0] i_fetch_addr = 0, i_data_addr = 0;
    reg  [7:0]  i_data_wdata = 0, i_dir_addr = 0, i_dir_wdata = 0;
    wire [7:0]  rd_fl, rd_sr, rd_id, rd_ra, rd_au, rd_us, rd_sf;
    wire o_sel_flash, o_sel_sram, o_sel_idata, o_sel_radio, o_sel_audio;
    wire o_sel_usb, o_sel_sfr, o_sel_core_sfr, o_we, o_is_fetch;
    wire o_bit_ok, o_bank_area, o_fetch_stall, o_data_ack, o_dir_ack;
    wire o_volatile_lost, o_flash_write_block;
    wire [15:0] o_offset;
    wire [7:0]  o_wdata, o_rdata;
    wire [7:0]  sel = {o_sel_flash, o_sel_sram, o_sel_idata, o_sel_radio,
                       o_sel_audio, o_sel_usb, o_sel_sfr, o_sel_core_sfr};
    integer     n_errors = 0, checks_done = 0, k;
    reg  [31:0] r;
    reg  [7:0]  got_sel, got_rd, got_wd;
    reg         got_we, got_blk, got_bit, got_bank;
    reg  [15:0] got_off;

    unified_memory_map_decoder unified_memory_map_decoder_inst (.*,
        .i_rdata_flash(rd_fl), .i_rdata_sram(rd_sr), .i_rdata_idata(rd_id),
        .i_rdata_radio(rd_ra), .i_rdata_audio(rd_au), .i_rdata_usb(rd_us),
        .i_rdata_sfr(rd_sf));
    target_model target_model_inst (.o_rdata_flash(rd_fl),
        .o_rdata_sram(rd_sr), .o_rdata_idata(rd_id), .o_rdata_radio(rd_ra),
        .o_rdata_audio(rd_au), .o_rdata_usb(rd_us), .o_rdata_sfr(rd_sf));

    // 250 mhz clock
    initial forever #2 i_clk = ~i_clk;

    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED at %0t: seen %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask

    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // bounded wait for the answer (0 data, 1 direct, 2 fetch); the
    // request stays up until then and drops just after, so the back in
    // idle cycle never sees it again; the fetch flag lingers, so the
    // take edge itself is skipped for fetches
    task wait_ans(input integer kind);
        integer n;
        reg     hit;
        begin
            hit = 0;
            got_blk = 0;
            for (n = 0; n < 20 && !hit; n = n + 1) begin
                @(posedge i_clk);
                #1;
                got_blk = got_blk | (o_flash_write_block === 1'b1);
                hit = kind == 0 ? o_data_ack === 1'b1 :
                      kind == 1 ? o_dir_ack === 1'b1 :
                      (n > 0 && o_is_fetch === 1'b1);
            end
            {got_sel, got_rd, got_wd} = {sel, o_rdata, o_wdata};
            {got_we, got_bit, got_bank} = {o_we, o_bit_ok, o_bank_area};
            got_off = o_offset;
            if (!hit) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED at %0t: no answer", $time);
                print_verdict;
            end
            i_data_req <= 0;
            i_dir_req <= 0;
            i_fetch_req <= 0;
            repeat (12) @(posedge i_clk);
        end
    endtask

    task data_op(input [15:0] a, input we, input dma);
        begin
            @(posedge i_clk);
            {i_data_req, i_data_we, i_data_is_dma} <= {1'b1, we, dma};
            i_data_addr <= a;
            i_data_wdata <= 8'h5A;
            wait_ans(0);
        end
    endtask

    // address, expected select vector, expected read byte
    function [31:0] row(input integer i);
        case (i)
            0: row = 32'h0000_8011;  1: row = 32'h7FFF_8011;
            2: row = 32'h8000_0000;  3: row = 32'hF000_4022;
            4: row = 32'hFDA2_4022;  5: row = 32'hFEFF_4022;
            6: row = 32'hFF00_2033;  7: row = 32'hFFFF_2033;
            8: row = 32'hDF00_1044;  9: row = 32'hDF3D_1044;
            10: row = 32'hDF3E_0000; 11: row = 32'hDF40_0855;
            12: row = 32'hDF48_0855; 13: row = 32'hDF49_0000;
            14: row = 32'hDF80_0277; 15: row = 32'hDFFF_0277;
            16: row = 32'hDE00_0466; 17: row = 32'hDE3F_0466;
            18: row = 32'hDE40_0000; default: row = 32'hEFFF_0000;
        endcase
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // every region edge read by cpu and dma alternately
    task test_map_reads;
        for (k = 0; k < 20; k = k + 1) begin
            r = row(k);
            data_op(r[31:16], 1'b0, k % 2);
            check(got_sel, r[15:8]);
            check(got_rd, r[7:0]);
        end
        $display("map reads done");
    endtask

    // fetches must land exactly where data reads land
    task test_fetch_map;
        for (k = 0; k < 20; k = k + 1) begin
            r = row(k);
            @(posedge i_clk);
            i_fetch_req <= 1;
            i_fetch_addr <= r[31:16];
            wait_ans(2);
            check(got_sel, r[15:8]);
        end
        $display("fetch map done");
    endtask

    // flash write refused, sram write carried through
    task test_writes;
        begin
            data_op(16'h0100, 1'b1, 1'b0);
            check(got_we, 1'b0);
            check(got_blk, 1'b1);
            data_op(16'hF010, 1'b1, 1'b1);
            check({got_we, got_sel, got_wd}, {1'b1, 8'h40, 8'h5A});
            check(got_off, 16'h0010);
            $display("writes done");
        end
    endtask

    // direct and indirect internal accesses: {addr, ind, sel, bit, bank}
    task test_direct;
        reg [18:0] d;
        for (k = 0; k < 7; k = k + 1) begin
            case (k)
                0: d = {8'h25, 1'b0, 8'h20, 2'b11};
                1: d = {8'h30, 1'b0, 8'h20, 2'b00};
                2: d = {8'h05, 1'b0, 8'h20, 2'b01};
                3: d = {8'h7F, 1'b0, 8'h20, 2'b00};
                4: d = {8'h85, 1'b0, 8'h01, 2'b00};
                5: d = {8'h88, 1'b0, 8'h01, 2'b10};
                default: d = {8'h85, 1'b1, 8'h20, 2'b00};
            endcase
            @(posedge i_clk);
            {i_dir_req, i_dir_we, i_dir_indirect} <= {1'b1, 1'b0, d[10]};
            i_dir_addr <= d[18:11];
            i_dir_wdata <= 8'hC3;
            wait_ans(1);
            check(got_sel, d[9:2]);
            check({got_bit, got_bank}, d[1:0]);
        end
        $display("direct access done");
    endtask

    // deepest sleep marks the volatile sram stretch
    task test_sleep;
        begin
            @(posedge i_clk);
            i_deep_sleep <= 1;
            repeat (3) @(posedge i_clk);
            #1;
            check(o_volatile_lost, 1'b1);
            @(posedge i_clk);
            i_deep_sleep <= 0;
            repeat (3) @(posedge i_clk);
            #1;
            check(o_volatile_lost, 1'b0);
            $display("sleep done");
        end
    endtask

    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_b <= 1;
        test_map_reads;
        test_fetch_map;
        test_writes;
        test_direct;
        test_sleep;
        print_verdict;
    end
endmodule // unified_memory_map_decoder_tb_top

bind unified_memory_map_decoder map_checker #(.SIZE_SEL(SIZE_SEL),
    .HAS_USB(HAS_USB), .DATA_WAIT(DATA_WAIT)) map_checker_inst (.*);
